// >>> hw/dts_top.v
/*
  Draw target select: holds the per-output target selection for
  windowed and object modes, checks target commands and routes fragment
  color writes to surfaces or image slots.
  Assumes the command issuer, bound id and fragment pipeline run on clk_in;
  surface straps are steady and are captured while reset is high.
  Selections are kept per mode, so switching the bound id swaps banks.
  Read data are zero outside the cycle that follows a read strobe.
  Error codes stay until a write to the error register clears them or a later command error replaces them.
*/
`timescale 1ns/1ps
// Overview of operation
// - Single-target command replaces output zero selection with decoded token.
// - Bound id zero means windowed mode, else object mode; reset windowed.
// - Windowed token enables zero, one, two or four surfaces.
// - Object slot token i enables only slot i, one destination.
// - Windowed single token naming no allocated surface gives bad-state error.
// - Object mode windowed token gives bad-state; slot beyond limit out-of-range.
// - Single token legal in neither mode gives unknown-token error.
// - Single-target command sets every other output to no target.
// - List assigns entry k to output k; outputs from n set none.
// - Multi-surface token in a list gives unknown-token error.
// - List count above output maximum gives out-of-range error.
// - Repeated non-none destination in one list gives bad-state error.
// - Windowed list entry naming unallocated surface gives bad-state error.
// - Object list entry windowed or slot beyond limit gives bad-state.
// - No-target outputs write nothing; others write current selection.
// - Single shader output goes everywhere; indexed outputs go separately.
// - Reset output zero: back, else front, else none; object slot zero.
// - Reset selection of outputs other than zero is no target.
// - Each output selection readable; unindexed query equals output zero.
// - Allocated surfaces fixed at initialization from mono/single straps.
// - Output zero none means no surface or slot change at all.
`include "dts_regs.vh"

module dts_top (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire [7:0]  addr_in,
  input  wire [31:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output wire [31:0] rdata_out,
  input  wire [7:0]  bound_target_object_id_in,
  input  wire        has_window_in,
  input  wire        stereo_in,
  input  wire        double_in,
  input  wire        frag_valid_in,
  input  wire        frag_single_in,
  output wire [3:0]  surf_we_out,
  output wire [7:0]  surf_src_out,
  output wire [7:0]  slot_we_out,
  output wire [15:0] slot_src_out,
  output wire        err_out,
  output wire [1:0]  err_code_out,
  output wire        object_mode_out
);

  // Selections, one token byte per output, per mode
  reg  [31:0] win_sel_reg;
  reg  [31:0] obj_sel_reg;
  reg  [31:0] win_sel_next;
  reg  [31:0] obj_sel_next;
  reg  [31:0] list_data_reg;
  reg  [3:0]  alloc_reg;
  reg  [1:0]  err_code_reg;
  reg  [1:0]  err_code_next;
  reg         err_reg;
  reg  [31:0] rdata_reg;
  reg  [31:0] rdata_next;
  // Registered fragment routing outputs
  reg  [3:0]  surf_we_reg;
  reg  [7:0]  surf_src_reg;
  reg  [7:0]  slot_we_reg;
  reg  [15:0] slot_src_reg;
  reg  [3:0]  surf_we_next;
  reg  [7:0]  surf_src_next;
  reg  [7:0]  slot_we_next;
  reg  [15:0] slot_src_next;
  // Command decode temporaries
  reg  [1:0]  cmd_err;
  reg  [1:0]  ent_err;
  reg         single_wr;
  reg         list_wr;
  reg  [7:0]  tok;
  reg  [7:0]  tok_j;
  reg  [7:0]  list_n;
  reg  [31:0] cur_sel;
  reg  [3:0]  strap_alloc;
  integer     k;
  integer     j;
  // Routing temporaries, kept apart from the command decode ones
  reg  [7:0]  rt_tok;
  reg  [3:0]  rt_mask;
  reg  [7:0]  sl_tok;
  integer     rk;
  integer     rj;
  integer     sk;

  wire obj_mode = |bound_target_object_id_in;

  // windowed token to surface mask {BR,BL,FR,FL}
  function [3:0] win_mask;
    input [7:0] t;
    begin
      case (t)
        `DTS_TOK_FL:    win_mask = 4'h1;
        `DTS_TOK_FR:    win_mask = 4'h2;
        `DTS_TOK_BL:    win_mask = 4'h4;
        `DTS_TOK_BR:    win_mask = 4'h8;
        `DTS_TOK_FRONT: win_mask = 4'h3;
        `DTS_TOK_BACK:  win_mask = 4'hC;
        `DTS_TOK_LEFT:  win_mask = 4'h5;
        `DTS_TOK_RIGHT: win_mask = 4'hA;
        `DTS_TOK_FAB:   win_mask = 4'hF;
        default:        win_mask = 4'h0;
      endcase
    end
  endfunction

  // Any windowed token, single or multi-surface
  function is_win;
    input [7:0] t;
    begin
      is_win = (t >= `DTS_TOK_FL) && (t <= `DTS_TOK_FAB);
    end
  endfunction

  // Any encodable slot token, in range or not
  function is_slot;
    input [7:0] t;
    begin
      is_slot = (t >= `DTS_TOK_SLOT0) && (t <= `DTS_TOK_SLOT_LAST);
    end
  endfunction

  // Slot token below the slot count limit
  function slot_ok;
    input [7:0] t;
    begin
      slot_ok = is_slot(t) && (t[3:0] < `DTS_SLOT_LIMIT);
    end
  endfunction

  always @* begin
    strap_alloc = {has_window_in & stereo_in & double_in,
                   has_window_in & double_in,
                   has_window_in & stereo_in,
                   has_window_in};
  end

  // Command checking and next selection state
  always @* begin
    single_wr    = wr_in && (addr_in == `DTS_SINGLE_CMD_ADDR);
    list_wr      = wr_in && (addr_in == `DTS_LIST_CMD_ADDR);
    tok          = wdata_in[7:0];
    list_n       = wdata_in[7:0];
    tok_j        = 8'h00;
    cmd_err      = `DTS_ERR_NONE;
    ent_err      = `DTS_ERR_NONE;
    win_sel_next = win_sel_reg;
    obj_sel_next = obj_sel_reg;
    if (single_wr) begin
      if (!obj_mode) begin
        if (!(tok == `DTS_TOK_NONE || is_win(tok) || is_slot(tok)))
          cmd_err = `DTS_ERR_ENUM;
        else if (tok != `DTS_TOK_NONE && (win_mask(tok) & alloc_reg) == 4'h0)
          cmd_err = `DTS_ERR_OP;
      end else begin
        if (!(tok == `DTS_TOK_NONE || is_win(tok) || is_slot(tok)))
          cmd_err = `DTS_ERR_ENUM;
        else if (is_win(tok))
          cmd_err = `DTS_ERR_OP;
        else if (is_slot(tok) && !slot_ok(tok))
          cmd_err = `DTS_ERR_VALUE;
      end
      if (cmd_err == `DTS_ERR_NONE) begin
        if (obj_mode)
          obj_sel_next = {24'h00_0000, tok};
        else
          win_sel_next = {24'h00_0000, tok};
      end
    end else if (list_wr) begin
      if (list_n > `DTS_MAX_OUT)
        cmd_err = `DTS_ERR_VALUE;
      else begin
        for (k = 0; k < `DTS_MAX_OUT; k = k + 1) begin
          tok = list_data_reg[k*8 +: 8];
          // Entries beyond the count are neither checked nor kept
          if (k < list_n) begin
            // only none, single surface or slot tokens
            if (!(tok <= `DTS_TOK_BR || is_slot(tok))) begin
              if (ent_err == `DTS_ERR_NONE)
                ent_err = `DTS_ERR_ENUM;
            end else if (tok != `DTS_TOK_NONE) begin
              if (!obj_mode && (is_slot(tok) || (win_mask(tok) & alloc_reg) == 4'h0)
                  && ent_err == `DTS_ERR_NONE)
                ent_err = `DTS_ERR_OP;
              // windowed token or slot beyond limit
              if (obj_mode && (is_win(tok) || !slot_ok(tok))
                  && ent_err == `DTS_ERR_NONE)
                ent_err = `DTS_ERR_OP;
              for (j = 0; j < `DTS_MAX_OUT; j = j + 1) begin
                tok_j = list_data_reg[j*8 +: 8];
                if (j < k && tok_j == tok && ent_err == `DTS_ERR_NONE)
                  ent_err = `DTS_ERR_OP;
              end
            end
          end
        end
        // First error found in list order wins
        tok = wdata_in[7:0];
        cmd_err = ent_err;
      end
      if (cmd_err == `DTS_ERR_NONE) begin
        // entry k to output k, beyond n none
        for (k = 0; k < `DTS_MAX_OUT; k = k + 1) begin
          if (obj_mode)
            obj_sel_next[k*8 +: 8] = (k < list_n) ? list_data_reg[k*8 +: 8]
                                                  : `DTS_TOK_NONE;
          else
            win_sel_next[k*8 +: 8] = (k < list_n) ? list_data_reg[k*8 +: 8]
                                                  : `DTS_TOK_NONE;
        end
      end
    end
  end

  // Error status: a new error overrides a clear
  // A clear and a command never share a cycle, but set still wins
  always @* begin
    err_code_next = err_code_reg;
    if (wr_in && addr_in == `DTS_ERR_ADDR)
      err_code_next = `DTS_ERR_NONE;
    if (cmd_err != `DTS_ERR_NONE)
      err_code_next = cmd_err;
  end

  // Selection and status registers
  always @(posedge clk_in) begin
    if (rst_in) begin
      alloc_reg     <= strap_alloc;
      if (has_window_in && double_in)
        win_sel_reg <= {24'h00_0000, `DTS_TOK_BACK};
      else if (has_window_in)
        win_sel_reg <= {24'h00_0000, `DTS_TOK_FRONT};
      else
        win_sel_reg <= 32'h0000_0000;
      obj_sel_reg   <= {24'h00_0000, `DTS_TOK_SLOT0};
      list_data_reg <= 32'h0000_0000;
      err_code_reg  <= `DTS_ERR_NONE;
      err_reg       <= 1'b0;
    end else begin
      win_sel_reg  <= win_sel_next;
      obj_sel_reg  <= obj_sel_next;
      err_code_reg <= err_code_next;
      err_reg      <= (cmd_err != `DTS_ERR_NONE);
      if (wr_in && addr_in == `DTS_LIST_DATA_ADDR)
        list_data_reg <= wdata_in;
    end
  end

  // Selection bank of the current mode
  always @* begin
    cur_sel = obj_mode ? obj_sel_reg : win_sel_reg;
  end

  // Surface routing from the current selections
  always @* begin
    rt_tok        = 8'h00;
    rt_mask       = 4'h0;
    surf_we_next  = 4'h0;
    surf_src_next = 8'h00;
    // output zero none blocks all writes
    if (frag_valid_in && !obj_mode && cur_sel[7:0] != `DTS_TOK_NONE) begin
      // each selected surface that is allocated takes its output
      for (rk = 0; rk < `DTS_MAX_OUT; rk = rk + 1) begin
        rt_tok  = cur_sel[rk*8 +: 8];
        rt_mask = win_mask(rt_tok);
        for (rj = 0; rj < 4; rj = rj + 1) begin
          if (rt_mask[rj] && alloc_reg[rj]) begin
            surf_we_next[rj] = 1'b1;
            surf_src_next[rj*2 +: 2] = frag_single_in ? 2'h0 : rk[1:0];
          end
        end
      end
    end
  end

  // Slot routing from the current selections
  always @* begin
    sl_tok        = 8'h00;
    slot_we_next  = 8'h00;
    slot_src_next = 16'h0000;
    // output zero none blocks all writes
    if (frag_valid_in && obj_mode && cur_sel[7:0] != `DTS_TOK_NONE) begin
      for (sk = 0; sk < `DTS_MAX_OUT; sk = sk + 1) begin
        sl_tok = cur_sel[sk*8 +: 8];
        if (slot_ok(sl_tok)) begin
          slot_we_next[sl_tok[2:0]] = 1'b1;
          slot_src_next[{sl_tok[2:0], 1'b0} +: 2] = frag_single_in ? 2'h0 : sk[1:0];
        end
      end
    end
  end

  // Routing outputs, one-cycle pulses
  always @(posedge clk_in) begin
    if (rst_in) begin
      surf_we_reg  <= 4'h0;
      surf_src_reg <= 8'h00;
      slot_we_reg  <= 8'h00;
      slot_src_reg <= 16'h0000;
    end else begin
      surf_we_reg  <= surf_we_next;
      surf_src_reg <= surf_src_next;
      slot_we_reg  <= slot_we_next;
      slot_src_reg <= slot_src_next;
    end
  end

  // Read decode; data valid the cycle after the strobe
  always @* begin
    rdata_next = 32'h0000_0000;
    if (rd_in) begin
      case (addr_in)
        `DTS_LIST_DATA_ADDR: rdata_next = list_data_reg;
        `DTS_ERR_ADDR:       rdata_next = {30'h0000_0000, err_code_reg};
        `DTS_SEL_BASE_ADDR:  rdata_next = {24'h00_0000, cur_sel[7:0]};
        `DTS_SEL1_ADDR:      rdata_next = {24'h00_0000, cur_sel[15:8]};
        `DTS_SEL2_ADDR:      rdata_next = {24'h00_0000, cur_sel[23:16]};
        `DTS_SEL3_ADDR:      rdata_next = {24'h00_0000, cur_sel[31:24]};
        `DTS_SEL_UNIDX_ADDR: rdata_next = {24'h00_0000, cur_sel[7:0]};
        `DTS_LIMITS_ADDR:    rdata_next = {16'h0000, `DTS_SLOT_LIMIT, `DTS_MAX_OUT};
        `DTS_MODE_ADDR:      rdata_next = {27'h000_0000, alloc_reg, obj_mode};
        default:             rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Read data register, zero unless a read was taken
  always @(posedge clk_in) begin
    if (rst_in)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= rdata_next;
  end

  // Outputs straight from flip-flops; mode flag follows the bound id
  assign rdata_out       = rdata_reg;
  assign surf_we_out     = surf_we_reg;
  assign surf_src_out    = surf_src_reg;
  assign slot_we_out     = slot_we_reg;
  assign slot_src_out    = slot_src_reg;
  assign err_out         = err_reg;
  assign err_code_out    = err_code_reg;
  assign object_mode_out = obj_mode;

endmodule

// >>> inc/dts_regs.vh
/*
  Constants for the draw target select block: register offsets, token
  encodings, error codes and sizes. Assumes a 32-bit register port.
*/
`ifndef DTS_REGS_VH
`define DTS_REGS_VH

// Register byte offsets
`define DTS_SINGLE_CMD_ADDR  8'h00
`define DTS_LIST_DATA_ADDR   8'h04
`define DTS_LIST_CMD_ADDR    8'h08
`define DTS_ERR_ADDR         8'h0C
`define DTS_SEL_BASE_ADDR    8'h10
`define DTS_SEL1_ADDR        8'h14
`define DTS_SEL2_ADDR        8'h18
`define DTS_SEL3_ADDR        8'h1C
`define DTS_SEL_UNIDX_ADDR   8'h20
`define DTS_LIMITS_ADDR      8'h24
`define DTS_MODE_ADDR        8'h28

// Sizes
`define DTS_MAX_OUT          8'h04
`define DTS_SLOT_LIMIT       8'h08
`define DTS_TOK_W            8
`define DTS_SEL_W            32

// Target tokens
`define DTS_TOK_NONE         8'h00
`define DTS_TOK_FL           8'h01
`define DTS_TOK_FR           8'h02
`define DTS_TOK_BL           8'h03
`define DTS_TOK_BR           8'h04
`define DTS_TOK_FRONT        8'h05
`define DTS_TOK_BACK         8'h06
`define DTS_TOK_LEFT         8'h07
`define DTS_TOK_RIGHT        8'h08
`define DTS_TOK_FAB          8'h09
`define DTS_TOK_SLOT0        8'h10
`define DTS_TOK_SLOT_LAST    8'h1F

// Error codes
`define DTS_ERR_NONE         2'h0
`define DTS_ERR_ENUM         2'h1
`define DTS_ERR_VALUE        2'h2
`define DTS_ERR_OP           2'h3

`endif

// >>> tb/dts_checker.sv
/* Port checker for dts_top.
   Assumes straps change only while reset is high. */
`timescale 1ns/1ps
module dts_checker (
  input logic        clk_in,
  input logic        rst_in,
  input logic [7:0]  addr_in,
  input logic        wr_in,
  input logic        rd_in,
  input logic [31:0] rdata_out,
  input logic [7:0]  bound_target_object_id_in,
  input logic        has_window_in,
  input logic        stereo_in,
  input logic        double_in,
  input logic        frag_valid_in,
  input logic [3:0]  surf_we_out,
  input logic [7:0]  slot_we_out,
  input logic        err_out,
  input logic [1:0]  err_code_out,
  input logic        object_mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Surfaces present, {BR,BL,FR,FL}
  wire [3:0] alloc = {has_window_in & stereo_in & double_in, has_window_in & double_in,
                      has_window_in & stereo_in, has_window_in};
  property p_mode; object_mode_out == (bound_target_object_id_in != 8'h00); endproperty
  a_mode: assert property (p_mode) else $error("mode flag wrong");
  property p_idle; !frag_valid_in |=> surf_we_out == 4'h0 && slot_we_out == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("write without fragment");
  property p_alloc; (surf_we_out & ~alloc) == 4'h0; endproperty
  a_alloc: assert property (p_alloc) else $error("absent surface written");
  property p_win; frag_valid_in && !object_mode_out |=> slot_we_out == 8'h00; endproperty
  a_win: assert property (p_win) else $error("slot written in windowed mode");
  property p_obj; frag_valid_in && object_mode_out |=> surf_we_out == 4'h0; endproperty
  a_obj: assert property (p_obj) else $error("surface written in object mode");
  property p_esrc;
    err_out |-> $past(wr_in) && ($past(addr_in) == 8'h00 || $past(addr_in) == 8'h08);
  endproperty
  a_esrc: assert property (p_esrc) else $error("error without command");
  property p_ecode; err_out |-> err_code_out != 2'h0; endproperty
  a_ecode: assert property (p_ecode) else $error("error pulse without code");
  property p_ehold; !wr_in |=> $stable(err_code_out); endproperty
  a_ehold: assert property (p_ehold) else $error("error code moved");
  property p_lim; rd_in && addr_in == 8'h24 |=> rdata_out[15:0] == 16'h0804; endproperty
  a_lim: assert property (p_lim) else $error("limits wrong");
  property p_rdz; !rd_in |=> rdata_out == 32'h0000_0000; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside slot");
endmodule

// >>> tb/dts_frag_src.sv
/* Fragment source model.
   Assumes requests are one-cycle pulses on go_in. */
`timescale 1ns/1ps
module dts_frag_src (
  input  logic clk_in,
  input  logic go_in,
  input  logic single_in,
  output logic frag_valid_out,
  output logic frag_single_out
);
  initial begin
    frag_valid_out = 1'b0;
    frag_single_out = 1'b0;
  end
  // one fragment, flag valid only with it
  always @(posedge clk_in) begin
    frag_valid_out <= go_in;
    frag_single_out <= go_in ? single_in : ~frag_single_out;
  end
endmodule

// >>> tb/draw_target_select_tb.sv
/* Testbench for dts_top.
   Assumes the register map and tokens of dts_regs.vh. */
`timescale 1ns/1ps
module draw_target_select_tb;
  logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, go = 0, sing = 0, hw = 1, st = 1, db = 1;
  logic [7:0]  addr_in = 0, bound = 0;
  logic [31:0] wdata_in = 0;
  wire [31:0] rdata;
  wire [3:0]  swe;
  wire [7:0]  ssrc, owe;
  wire [15:0] osrc;
  wire [1:0]  ecode;
  wire        err, fv, fs;
  int miscompares = 0, n_tests = 0, cyc = 0;
  logic [3:0] wes [0:9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'h5, 4'hA, 4'hF};
  dts_top uut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .bound_target_object_id_in(bound),
    .has_window_in(hw), .stereo_in(st), .double_in(db), .frag_valid_in(fv),
    .frag_single_in(fs), .surf_we_out(swe), .surf_src_out(ssrc), .slot_we_out(owe),
    .slot_src_out(osrc), .err_out(err), .err_code_out(ecode), .object_mode_out());
  dts_frag_src u_src (.clk_in(clk_in), .go_in(go), .single_in(sing), .frag_valid_out(fv),
    .frag_single_out(fs));
  initial forever #2 clk_in = ~clk_in;
  // Cut a hang short
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task rst(input logic h, input logic s, input logic d);
    @(posedge clk_in);
    rst_in <= 1;
    hw <= h;
    st <= s;
    db <= d;
    repeat (20) @(posedge clk_in);
    rst_in <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 0;
    #1;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    rd_in <= 1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 0;
    #1 chk(rdata, e, "read");
  endtask
  task cmd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    wr(a, d);
    chk(err, e != 2'h0, "err pulse");
    if (e != 2'h0) chk(ecode, e, "err code");
  endtask
  task lst(input logic [31:0] d, input logic [7:0] n, input logic [1:0] e);
    wr(8'h04, d);
    cmd(8'h08, n, e);
  endtask
  task frg(input logic s, input logic [3:0] es, input logic [7:0] ss, input logic [7:0] eo);
    @(posedge clk_in);
    go <= 1;
    sing <= s;
    @(posedge clk_in);
    go <= 0;
    @(posedge clk_in);
    #1 chk(swe, es, "surf we");
    chk(ssrc, ss, "surf src");
    chk(owe, eo, "slot we");
  endtask
  task t_full;
    rdc(8'h10, 8'h06);
    for (int i = 1; i < 4; i++) rdc(8'h10 + 8'(4 * i), 8'h00);
    rdc(8'h20, 8'h06);
    rdc(8'h28, 8'h1E);
    rdc(8'h30, 8'h00);
    rdc(8'h24, 32'h0000_0804);
    frg(1, 4'hC, 8'h00, 8'h00);
    $display("test reset values done");
  endtask
  task t_single;
    lst(32'h0403_0201, 4, 0);
    frg(0, 4'hF, 8'hE4, 8'h00);
    for (int i = 0; i < 10; i++) begin
      cmd(8'h00, i, 0);
      rdc(8'h10, i);
      rdc(8'h14, 8'h00);
      frg(1, wes[i], 8'h00, 8'h00);
    end
    $display("test single target done");
  endtask
  task t_errs;
    cmd(8'h00, 8'h01, 0);
    cmd(8'h00, 8'h0A, 1);
    cmd(8'h00, 8'hFF, 1);
    cmd(8'h00, 8'h10, 3);
    lst(32'h0000_0005, 1, 1);
    lst(32'h0403_0201, 5, 2);
    lst(32'h0000_0101, 2, 3);
    rdc(8'h10, 8'h01);
    lst(32'h0403_0201, 2, 0);
    rdc(8'h14, 8'h02);
    rdc(8'h18, 8'h00);
    rdc(8'h0C, 8'h03);
    wr(8'h0C, 8'h00);
    rdc(8'h0C, 8'h00);
    $display("test errors done");
  endtask
  task t_mono;
    rdc(8'h10, 8'h05);
    rdc(8'h28, 8'h02);
    cmd(8'h00, 8'h04, 3);
    lst(32'h0000_0002, 1, 3);
    frg(1, 4'h1, 8'h00, 8'h00);
    @(posedge clk_in) bound <= 8'h01;
    rdc(8'h10, 8'h10);
    rdc(8'h28, 8'h03);
    cmd(8'h00, 8'h13, 0);
    frg(1, 4'h0, 8'h00, 8'h08);
    cmd(8'h00, 8'h18, 2);
    cmd(8'h00, 8'h01, 3);
    lst(32'h0000_0018, 1, 3);
    lst(32'h0000_0001, 1, 3);
    lst(32'h0000_1211, 2, 0);
    frg(0, 4'h0, 8'h00, 8'h06);
    chk(osrc, 16'h0010, "slot src");
    cmd(8'h00, 8'h00, 0);
    frg(1, 4'h0, 8'h00, 8'h00);
    @(posedge clk_in) bound <= 8'h00;
    rdc(8'h10, 8'h05);
    $display("test mono and object done");
  endtask
  task t_nowin;
    rdc(8'h10, 8'h00);
    rdc(8'h28, 8'h00);
    frg(1, 4'h0, 8'h00, 8'h00);
    cmd(8'h00, 8'h01, 3);
    $display("test no window done");
  endtask
  initial begin
    rst(1, 1, 1);
    t_full;
    t_single;
    t_errs;
    rst(1, 0, 0);
    t_mono;
    rst(0, 0, 0);
    t_nowin;
    report_and_stop;
  end
endmodule
bind dts_top dts_checker u_chk (.clk_in, .rst_in, .addr_in, .wr_in, .rd_in, .rdata_out,
  .bound_target_object_id_in, .has_window_in, .stereo_in, .double_in, .frag_valid_in,
  .surf_we_out, .slot_we_out, .err_out, .err_code_out, .object_mode_out);
